// ==== bench/switch_monitor_cmd_assertions.sv ====
// Purpose: Port-level properties of the switch monitor decoder
// Assumes: One clock domain, synchronous reset
// Notes:   Pulse length judged only on pulses no event explains
`timescale 1ns/1ns
module switch_monitor_cmd_assertions #(
  parameter int RELEASE_CYC = 10000
)(
  // Watched ports
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic miso_oe_r,
  input wire logic fault_status,
  input wire logic change_event,
  input wire logic int_n_r,
  input wire logic soft_reset_r,
  input wire logic change_flag_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic        prev_r;
  logic        own_r;
  logic [15:0] cnt_r;
  ////////////////////////////////////////
  // Low-time counter of the interrupt output
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      prev_r <= 1'b1;
      own_r  <= 1'b0;
      cnt_r  <= 16'h0;
    end
    else
    begin
      prev_r <= int_n_r;
      if (prev_r && !int_n_r)
      begin
        own_r <= !change_flag_r && !fault_status;
        cnt_r <= 16'h1;
      end
      else if (!int_n_r)
        cnt_r <= cnt_r + 16'h1;
    end
  end
  ////////////////////////////////////////
  sequence s_evt;
    change_event;
  endsequence
  sequence s_sel;
    $fell(cs_n);
  endsequence
  property p_irq_len;
    int_n_r && !prev_r && own_r |-> cnt_r == swmon_pkg::IRQ_PULSE_CYC;
  endproperty
  property p_evt_flag;
    s_evt |=> change_flag_r;
  endproperty
  property p_evt_int;
    s_evt |-> ##2 !int_n_r;
  endproperty
  property p_flag_cause;
    $rose(change_flag_r) |-> $past(change_event) ||
      ($past(fault_status) && !$past(fault_status, 2));
  endproperty
  property p_flag_hold;
    change_flag_r && !cs_n |=> change_flag_r;
  endproperty
  property p_rst_one;
    soft_reset_r |-> $past(cs_n, 4) ##1 !soft_reset_r;
  endproperty
  property p_oe_on;
    s_sel |-> ##[3:8] miso_oe_r;
  endproperty
  property p_oe_off;
    $rose(cs_n) |-> ##[3:8] !miso_oe_r;
  endproperty
  property p_oe_hold;
    miso_oe_r && !cs_n |=> miso_oe_r;
  endproperty
  a_irq_len: assert property (p_irq_len)
    else $error("interrupt pulse length wrong");
  a_evt_flag: assert property (p_evt_flag)
    else $error("event did not set flag");
  a_evt_int: assert property (p_evt_int)
    else $error("event did not pull interrupt low");
  a_flag_cause: assert property (p_flag_cause)
    else $error("flag rose without an event");
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag cleared inside a frame");
  a_rst_one: assert property (p_rst_one)
    else $error("soft reset pulse malformed");
  a_oe_on: assert property (p_oe_on)
    else $error("output not enabled after select");
  a_oe_off: assert property (p_oe_off)
    else $error("output not released after select");
  a_oe_hold: assert property (p_oe_hold)
    else $error("output dropped inside a frame");
endmodule
bind switch_monitor_cmd switch_monitor_cmd_assertions #(
  .RELEASE_CYC(RELEASE_CYC)
) switch_monitor_cmd_assertions_i (
  .sys_clk(sys_clk),
  .reset(reset),
  .cs_n(cs_n),
  .miso_oe_r(miso_oe_r),
  .fault_status(fault_status),
  .change_event(change_event),
  .int_n_r(int_n_r),
  .soft_reset_r(soft_reset_r),
  .change_flag_r(change_flag_r)
);

// ==== bench/switch_monitor_cmd_tb.sv ====
// Purpose: Command-level test of the switch monitor decoder
// Assumes: Short release count; master model drives the link
// Notes:   Answers arrive one frame late, so checks trail commands
`timescale 1ns/1ns
module switch_monitor_cmd_tb;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        fault_status = 1'b0;
  logic        change_event = 1'b0;
  logic [21:0] switch_status = 22'h2a5a5a;
  logic        sclk, cs_n, mosi, miso_r, miso_oe_r;
  logic        int_n_r, soft_reset_r, change_flag_r;
  logic [31:0] resp;
  int          n_fail = 0;
  int          n_tests = 0;
  int          n_srst = 0;
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (soft_reset_r === 1'b1) n_srst++;
  switch_monitor_cmd #(.RELEASE_CYC(200)) switch_monitor_cmd_i (
    .sys_clk(sys_clk), .reset(reset), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso_r(miso_r), .miso_oe_r(miso_oe_r),
    .fault_status(fault_status), .change_event(change_event),
    .switch_status(switch_status), .int_n_r(int_n_r),
    .soft_reset_r(soft_reset_r), .change_flag_r(change_flag_r));
  swmon_mcu swmon_mcu_i (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso_r));
  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic frame(input logic [31:0] c, input int n);
    swmon_mcu_i.xfer(c, n, resp);
    tick(1);
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    #3000000;
    n_fail++;
    report_and_stop;
  end
  initial
  begin
    tick(6);
    reset = 1'b0;
    tick(4);
    chk("idle", 32'h4, {29'h0, int_n_r, change_flag_r, miso_oe_r});
    frame(32'h4700_0000, 32);
    chk("int_n", 32'h0, 32'(int_n_r));
    chk("flag", 32'h0, 32'(change_flag_r));
    tick(1000);
    chk("int_n", 32'h1, 32'(int_n_r));
    frame(32'h4700_0001, 32);
    chk("resp", 32'h4700_0000, resp);
    for (int i = 0; i < 2; i++)
    begin
      frame(i ? 32'h4600_0000 : 32'h4700_0000, 31 + i);
      chk("code", 32'h0, resp & 32'hff00_0000);
      chk("int_n", 32'h1, 32'(int_n_r));
    end
    change_event = 1'b1;
    tick(1);
    change_event = 1'b0;
    fault_status = 1'b1;
    tick(3);
    chk("flag", 32'h1, 32'(change_flag_r));
    chk("int_n", 32'h0, 32'(int_n_r));
    frame(32'h4900_0000, 32);
    chk("srst", 32'h1, 32'(n_srst));
    chk("flag", 32'h0, 32'(change_flag_r));
    frame(32'h0, 32);
    chk("resp", {8'h3e, 2'b10, switch_status}, resp);
    chk("int_n", 32'h0, 32'(int_n_r));
    fault_status = 1'b0;
    frame(32'h0, 32);
    chk("int_n", 32'h1, 32'(int_n_r));
    frame(32'h4700_0000, 32);
    change_event = 1'b1;
    tick(1);
    change_event = 1'b0;
    fault_status = 1'b1;
    frame(32'h0, 32);
    chk("resp", {8'h47, 2'b11, 22'h0}, resp);
    report_and_stop;
  end
endmodule

// ==== bench/swmon_mcu.sv ====
// Purpose: Serial master model sending mode 0 frames
// Assumes: 800 ns link period, MSB first
// Notes:   Data moves mid low phase, clear of the slow pin filter
`timescale 1ns/1ns
module swmon_mcu (
  // Link pins
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Counts other than 32 only for refused frames
  task automatic xfer(input logic [31:0] c, input int n,
                      output logic [31:0] r);
    // Cleared so a short frame leaves no unknown bits behind
    r = 32'h0000_0000;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      #250 mosi = c[31 - i];
      #150 sclk = 1'b1;
      #390 r = {r[30:0], miso};
      #10 sclk = 1'b0;
    end
    #250 mosi = ~mosi;
    #150 cs_n = 1'b1;
    #1200;
  endtask
endmodule

// ==== src/link_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs are asynchronous to sys_clk
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ns
module link_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
)(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // Pins
  input  wire logic [WIDTH-1:0] pin_in,
  // Filtered level
  output logic      [WIDTH-1:0] level_r
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Per-bit agreement so one noisy pin cannot hold the others back
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    always_ff @(posedge sys_clk)
    begin
      if (reset)
        level_r[i] <= INIT[i];
      else if (s2_r[i] == s3_r[i])
        level_r[i] <= s3_r[i];
    end
  end

endmodule

// ==== src/switch_monitor_cmd.sv ====
// Purpose: Serial command decoder for interrupt request and soft reset
// Assumes: Mode 0 link, MSB first; fault and switch inputs on sys_clk
// Notes:   Answer to a command is shifted out during the next frame
//
// Behaviour
// - Interrupt request command pulses the active-low interrupt output 100 us.
// - Interrupt request frame is address 0x23, write bit set, zero data.
// - Interrupt request answer echoes code, fault bit, change flag, zeros.
// - Interrupt request command never sets the change-event flag itself.
// - Soft reset frame (0x23+1, write, zero data) restores programmable registers.
// - Soft reset answer carries code 0x3e, fault, change flag, switch status.
// - Frame opens with chip select falling; exactly 32 clocks shift a word.
// - Flag clears once returned; a persisting fault raises no new event.
// - Interrupt output released 1.0 ms after select falls, held if fault.
`timescale 1ns/1ns
module switch_monitor_cmd #(
  parameter int RELEASE_CYC = swmon_pkg::RELEASE_CYC
)(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Serial link pins
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output logic             miso_r,
  output logic             miso_oe_r,
  // Device status
  input  wire logic        fault_status,
  input  wire logic        change_event,
  input  wire logic [21:0] switch_status,
  // Device controls
  output logic             int_n_r,
  output logic             soft_reset_r,
  output logic             change_flag_r
);

  // Release count must fit the timer
  if (RELEASE_CYC < 1 || RELEASE_CYC >= (1 << swmon_pkg::TIMER_W))
  begin : g_bad_release
    $error("RELEASE_CYC out of timer range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edges

  logic [2:0] pins_lvl;
  logic       sclk_q_r;
  logic       cs_q_r;

  link_sync #(
    .WIDTH (3),
    .INIT  (3'h2)
  ) u_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .pin_in  ({mosi, cs_n, sclk}),
    .level_r (pins_lvl)
  );

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      sclk_q_r <= 1'b0;
      cs_q_r   <= 1'b1;
    end
    else
    begin
      sclk_q_r <= pins_lvl[0];
      cs_q_r   <= pins_lvl[1];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic in_frame;

  assign sclk_rise = pins_lvl[0] & ~sclk_q_r;
  assign sclk_fall = ~pins_lvl[0] & sclk_q_r;
  assign cs_fall   = ~pins_lvl[1] & cs_q_r;
  assign cs_rise   = pins_lvl[1] & ~cs_q_r;
  assign in_frame  = ~cs_q_r;

  ////////////////////////////////////////////////////////////////////////////
  // Receive shifter and bit counter

  logic [31:0] rx_r;
  logic [5:0]  bits_r;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      rx_r   <= 32'h0000_0000;
      bits_r <= 6'h00;
    end
    else if (cs_fall)
      bits_r <= 6'h00;
    else if (in_frame && sclk_rise)
    begin
      rx_r <= {rx_r[30:0], pins_lvl[2]};
      if (bits_r != 6'h3f)
        bits_r <= bits_r + 6'h01;
    end
  end

  // Frame counts only with exactly 32 clocks, judged when select rises
  logic frame_ok;
  logic is_irq;
  logic is_rst;

  assign frame_ok = cs_rise && bits_r == 6'(swmon_pkg::FRAME_BITS);

  function automatic logic cmd_match(input logic [31:0] w,
                                     input logic [6:0]  addr);
    cmd_match = w[swmon_pkg::ADDR_MSB:swmon_pkg::ADDR_LSB] == addr
             && w[swmon_pkg::WRITE_BIT]
             && w[swmon_pkg::DATA_BITS-1:0] == 24'h00_0000;
  endfunction

  assign is_irq = frame_ok && cmd_match(rx_r, swmon_pkg::ADDR_IRQ_REQ);
  assign is_rst = frame_ok && cmd_match(rx_r, swmon_pkg::ADDR_SOFT_RST);

  ////////////////////////////////////////////////////////////////////////////
  // Pending answer for the next frame

  swmon_pkg::resp_t resp_r;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      resp_r <= swmon_pkg::RESP_IDLE;
    else if (is_irq)
      resp_r <= swmon_pkg::RESP_IRQ;
    else if (is_rst)
      resp_r <= swmon_pkg::RESP_RST;
    else if (frame_ok)
      resp_r <= swmon_pkg::RESP_IDLE;
  end

  // Soft reset strobe for the programmable register bank
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      soft_reset_r <= 1'b0;
    else
      soft_reset_r <= is_rst;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Change-event flag

  logic fault_q_r;
  logic flag_sent_r;
  logic fault_rise;

  assign fault_rise = fault_status & ~fault_q_r;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      fault_q_r <= 1'b0;
    else
      fault_q_r <= fault_status;
  end

  // Only real events set it; the set wins over a same-cycle clear
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      change_flag_r <= 1'b0;
    else if (change_event || fault_rise)
      change_flag_r <= 1'b1;
    else if (frame_ok && flag_sent_r)
      change_flag_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit shifter

  logic [31:0] tx_r;
  logic [31:0] tx_load;

  always_comb
  begin
    tx_load = 32'h0000_0000;
    unique case (resp_r)
      swmon_pkg::RESP_IRQ:
        tx_load[31:swmon_pkg::CODE_LSB] = swmon_pkg::CODE_IRQ_REQ;
      swmon_pkg::RESP_RST:
      begin
        tx_load[31:swmon_pkg::CODE_LSB] = swmon_pkg::CODE_SOFT_RST;
        tx_load[swmon_pkg::SWITCH_BITS-1:0] = switch_status;
      end
      swmon_pkg::RESP_IDLE:
        tx_load[31:swmon_pkg::CODE_LSB] = swmon_pkg::CODE_IDLE;
      default:
        tx_load[31:swmon_pkg::CODE_LSB] = swmon_pkg::CODE_IDLE;
    endcase
    tx_load[swmon_pkg::FAULT_BIT] = fault_status;
    tx_load[swmon_pkg::FLAG_BIT]  = change_flag_r;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      tx_r        <= 32'h0000_0000;
      flag_sent_r <= 1'b0;
    end
    else if (cs_fall)
    begin
      tx_r        <= tx_load;
      flag_sent_r <= change_flag_r;
    end
    else if (in_frame && sclk_fall)
      tx_r <= {tx_r[30:0], 1'b0};
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      miso_r    <= 1'b0;
      miso_oe_r <= 1'b0;
    end
    else
    begin
      miso_r    <= cs_fall ? tx_load[31] : tx_r[31];
      miso_oe_r <= ~pins_lvl[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt output

  logic [swmon_pkg::TIMER_W-1:0] pulse_cnt_r;
  logic [swmon_pkg::TIMER_W-1:0] rel_cnt_r;
  logic                          event_hold_r;
  logic                          rel_done;

  // Pulse length fixed; a second request reloads the count and restarts it
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      pulse_cnt_r <= '0;
    else if (is_irq)
      pulse_cnt_r <= swmon_pkg::TIMER_W'(swmon_pkg::IRQ_PULSE_CYC);
    else if (pulse_cnt_r != '0)
      pulse_cnt_r <= pulse_cnt_r - swmon_pkg::TIMER_W'(1);
  end

  assign rel_done = rel_cnt_r == swmon_pkg::TIMER_W'(1);

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      rel_cnt_r <= '0;
    else if (cs_fall)
      rel_cnt_r <= swmon_pkg::TIMER_W'(RELEASE_CYC);
    else if (rel_cnt_r != '0)
      rel_cnt_r <= rel_cnt_r - swmon_pkg::TIMER_W'(1);
  end

  // A new event wins over a same-cycle timed release
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      event_hold_r <= 1'b0;
    else if (change_event || fault_rise)
      event_hold_r <= 1'b1;
    else if (rel_done)
      event_hold_r <= fault_status;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      int_n_r <= 1'b1;
    else
      int_n_r <= ~(event_hold_r || pulse_cnt_r != '0);
  end

endmodule

// ==== src/swmon_pkg.sv ====
// Purpose: Shared constants for the switch monitor command decoder
// Assumes: 10 MHz system clock, 32-bit frames, MSB first
// Notes:   Times are kept in their own unit; cycle counts derive from them
package swmon_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 100;

  // Frame layout
  localparam int FRAME_BITS    = 32;
  localparam int ADDR_MSB      = 31;
  localparam int ADDR_LSB      = 25;
  localparam int WRITE_BIT     = 24;
  localparam int DATA_BITS     = 24;
  localparam int FAULT_BIT     = 23;
  localparam int FLAG_BIT      = 22;
  localparam int SWITCH_BITS   = 22;
  localparam int CODE_LSB      = 24;

  // Register addresses
  localparam logic [6:0] ADDR_IRQ_REQ   = 7'h23;
  localparam logic [6:0] ADDR_SOFT_RST  = 7'h24;

  // Return codes
  localparam logic [7:0] CODE_IRQ_REQ   = 8'h47;
  localparam logic [7:0] CODE_SOFT_RST  = 8'h3e;
  localparam logic [7:0] CODE_IDLE      = 8'h00;

  // Timing
  localparam int IRQ_PULSE_US    = 100;
  localparam int IRQ_PULSE_CYC   = (IRQ_PULSE_US * 1000) / CLK_PERIOD_NS;
  localparam int RELEASE_US      = 1000;
  localparam int RELEASE_CYC     = (RELEASE_US * 1000) / CLK_PERIOD_NS;
  localparam int TIMER_W         = 16;

  // Pending response selector
  typedef enum logic [1:0] {RESP_IDLE, RESP_IRQ, RESP_RST} resp_t;

endpackage
